// file: core/wdg_consts.vh
// constants for the windowed reset watchdog
// assumes inclusion by bare name from the core design file
`ifndef WDG_CONSTS_VH
`define WDG_CONSTS_VH

// ****************************************
// register map
// ****************************************
`define WDG_CTRL_ADDR     12'h00c
`define WDG_CTRL_RESET    8'h7f
`define WDG_ACT_BIT       7
`define WDG_CNT_MSB       6
`define WDG_TOP_BIT       6
`define WDG_CNT_RESET     7'h7f
`define WDG_ACT_RESET     1'b0
`define WDG_FIRE_COUNT    7'h40

// ****************************************
// timing
// ****************************************
`define WDG_TICK_DIV      16'h0fa0
`define WDG_RST_PULSE     4'h8

`endif

// file: core/windowed_reset_watchdog.v
// software-activated watchdog with a 7-bit down-counter, APB slave
// assumes one 20 MHz clock, async active-high reset, synchronous inputs
//
// How it works
// - writing one to bit 7 activates watchdog
// - activation bit ignores clears until reset
// - no watchdog reset while not activated
// - bits 6:0 hold readable down-counter value
// - reset fires when counter steps 40h to 3fh
// - control register resets to 7fh
// - counting continues during processor wait state
//
// The APB interface to the registers was chosen for this implementation.
`timescale 1ns/10ps
`include "wdg_consts.vh"

module windowed_reset_watchdog #(
  parameter TICK_DIV = `WDG_TICK_DIV
) (
  input  wire        ref_clk,
  input  wire        sys_rst,
  input  wire        psel,
  input  wire        penable,
  input  wire        pwrite,
  input  wire [11:0] paddr,
  input  wire [31:0] pwdata,
  output reg  [31:0] prdata,
  output reg         pready,
  output reg         pslverr,
  output reg         wdg_reset_out
);

  // ****************************************
  // state
  // ****************************************
  reg         watchdog_activate_reg;
  reg  [6:0]  count_reg;
  reg  [15:0] presc_reg;
  reg  [3:0]  pulse_reg;
  reg  [6:0]  count_next;
  reg         act_next;
  wire        setup;
  wire        hit;
  wire        tick;
  wire        wr;
  wire        fire;

  assign setup = psel & ~penable;
  assign hit   = (paddr == `WDG_CTRL_ADDR);
  assign wr    = psel & penable & pready & pwrite & hit;
  assign tick  = (presc_reg == TICK_DIV[15:0] - 16'h0001);
  assign fire  = watchdog_activate_reg & tick & ~wr &
                 (count_reg == `WDG_FIRE_COUNT);

  // ****************************************
  // apb slave, no wait states
  // ****************************************
  always @(posedge ref_clk or posedge sys_rst) begin
    if (sys_rst) begin
      pready  <= 1'b0;
      pslverr <= 1'b0;
      prdata  <= 32'h00000000;
    end else begin
      pready  <= setup;
      pslverr <= setup & ~hit;
      if (setup & ~pwrite & hit) begin
        prdata <= {24'h000000, watchdog_activate_reg, count_reg};
      end else if (setup) begin
        prdata <= 32'h00000000;
      end
    end
  end

  // ****************************************
  // counter and activation
  // ****************************************
  always @* begin
    act_next   = watchdog_activate_reg;
    count_next = count_reg;
    if (tick) begin
      count_next = count_reg - 7'h01;
    end
    if (wr) begin
      count_next = pwdata[`WDG_CNT_MSB:0];
      act_next = watchdog_activate_reg | pwdata[`WDG_ACT_BIT];
    end
  end

  always @(posedge ref_clk or posedge sys_rst) begin
    if (sys_rst) begin
      watchdog_activate_reg <= `WDG_ACT_RESET;
      count_reg             <= `WDG_CNT_RESET;
      presc_reg             <= 16'h0000;
      pulse_reg             <= 4'h0;
      wdg_reset_out         <= 1'b0;
    end else begin
      watchdog_activate_reg <= act_next;
      count_reg             <= count_next;
      presc_reg             <= tick ? 16'h0000 : presc_reg + 16'h0001;
      if (fire) begin
        pulse_reg <= `WDG_RST_PULSE;
      end else if (pulse_reg != 4'h0) begin
        pulse_reg <= pulse_reg - 4'h1;
      end
      wdg_reset_out <= fire | (pulse_reg > 4'h1);
    end
  end

endmodule // windowed_reset_watchdog

// file: verif/wdg_monitor.sv
// port checker for the watchdog
// assumes bind onto the top module
`timescale 1ns/10ps
// ****
// checks
// ****
module wdg_monitor (
  input wire ref_clk, sys_rst, psel, penable, pready, pslverr,
  input wire wdg_reset_out,
  input wire [11:0] paddr
);
  default clocking @(posedge ref_clk); endclocking
  default disable iff (sys_rst);
  sequence s_setup; psel && !penable; endsequence
  property p_ans; s_setup |=> pready; endproperty
  a_ans: assert property (p_ans) else $error("no ready");
  property p_err; pready |-> pslverr == (paddr != 12'h00c); endproperty
  a_err: assert property (p_err) else $error("bad slverr");
  property p_one; pready |=> !pready; endproperty
  a_one: assert property (p_one) else $error("long ready");
  property p_pulse;
    $rose(wdg_reset_out) |-> wdg_reset_out[*8] ##1 !wdg_reset_out;
  endproperty
  a_pulse: assert property (p_pulse) else $error("bad pulse");
  sequence s_idle; !psel; endsequence
  property p_idle; s_idle |=> !pready; endproperty
  a_idle: assert property (p_idle) else $error("stray ready");
  property p_noerr; !pready |-> !pslverr; endproperty
  a_noerr: assert property (p_noerr) else $error("stray slverr");
endmodule // wdg_monitor
bind windowed_reset_watchdog wdg_monitor mon_u (.ref_clk, .sys_rst,
  .psel, .penable, .pready, .pslverr, .wdg_reset_out, .paddr);

// file: verif/windowed_reset_watchdog_test.sv
// bench for the watchdog over apb
// assumes the checker file is compiled first
`timescale 1ns/10ps
// ****
// bench
// ****
module windowed_reset_watchdog_test;
  logic ref_clk, sys_rst, psel, penable, pwrite, pready, pslverr, wro;
  logic [11:0] paddr;
  logic [31:0] pwdata, prdata, rd;
  logic fired = 0;
  logic err = 0;
  int miscompares = 0, total_checks = 0;
  windowed_reset_watchdog #(.TICK_DIV(64)) dut_u (.ref_clk, .sys_rst,
    .psel, .penable, .pwrite, .paddr, .pwdata, .prdata, .pready,
    .pslverr, .wdg_reset_out(wro));
  initial begin
    ref_clk = 0;
    forever #25 ref_clk = ~ref_clk;
  end
  always @(posedge ref_clk) if (wro === 1) fired <= 1;
  task xfer(input bit w, input [11:0] a, input [7:0] d);
    int n;
    @(posedge ref_clk);
    psel <= 1; pwrite <= w; paddr <= a; pwdata <= {24'h0, d};
    @(posedge ref_clk);
    penable <= 1;
    n = 0;
    do @(posedge ref_clk); while (pready !== 1 && ++n < 50);
    rd = prdata;
    err = pslverr;
    psel <= 0; penable <= 0;
  endtask
  task chk(input bit ok);
    total_checks++;
    if (!ok) begin
      miscompares++;
      $display("unexpected %0t mismatch", $time);
    end
  endtask
  task summarize;
    $display("checks %0d miscompares %0d", total_checks, miscompares);
    if (miscompares == 0 && total_checks > 0) $display("Finished cleanly");
    else $display("Finished with errors");
    $finish;
  endtask
  initial begin
    {psel, penable, pwrite, paddr, pwdata} = 0;
    sys_rst = 1;
    repeat (3) @(posedge ref_clk);
    sys_rst <= 0;
    xfer(0, 12'h00c, 0); chk(rd === 32'h7f);
    xfer(1, 12'h00c, 8'h41); repeat (300) @(posedge ref_clk);
    chk(fired === 0); xfer(0, 12'h00c, 0); chk(rd[7] === 0);
    xfer(1, 12'h00c, 8'hc1); xfer(0, 12'h00c, 0);
    chk(rd[7:0] === 8'hc1 || rd[7:0] === 8'hc0);
    xfer(1, 12'h00c, 8'h45); xfer(0, 12'h00c, 0);
    chk(rd[7:0] === 8'hc5 || rd[7:0] === 8'hc4);
    repeat (600) @(posedge ref_clk); chk(fired === 1);
    xfer(0, 12'h010, 0); chk(rd === 0 && err === 1);
    summarize;
  end
  initial begin
    #100000;
    miscompares++;
    summarize;
  end
endmodule // windowed_reset_watchdog_test
